// File: sps_pkg.sv
package sps_pkg;

    // ------------------------------------------------------------
    // time base
    // ------------------------------------------------------------
    localparam int unsigned CLK_HZ = 200_000_000;
    localparam int unsigned TICK_S = 1;
    localparam int unsigned CYCLES_PER_SEC = CLK_HZ * TICK_S;
    localparam int unsigned SEC_PER_MIN = 60;

    // ------------------------------------------------------------
    // profile storage layout
    // ------------------------------------------------------------
    localparam int NUM_PROFILES = 5;
    localparam int MEM_WORDS = 11;
    localparam logic [2:0] NUM_SEG = 3'h4;
    localparam logic [2:0] PROF_FIRST = 3'h1;
    localparam logic [2:0] PROF_LAST = 3'h5;
    localparam logic [3:0] DUR_IDX0 = 4'h5;
    localparam logic [3:0] EVT_IDX = 4'h9;
    localparam logic [3:0] LINK_IDX = 4'ha;

    // ------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------
    localparam logic [11:0] OFF_CTRL = 12'h000;
    localparam logic [11:0] OFF_RATE = 12'h004;
    localparam logic [11:0] OFF_TOL = 12'h008;
    localparam logic [11:0] OFF_TARGET = 12'h00c;
    localparam logic [11:0] OFF_STATUS = 12'h010;
    localparam logic [11:0] OFF_IRQ_STAT = 12'h014;
    localparam logic [11:0] OFF_IRQ_MASK = 12'h018;
    localparam logic [11:0] MEM_BASE = 12'h100;
    localparam logic [11:0] MEM_END = 12'h240;

    // ------------------------------------------------------------
    // field codes
    // ------------------------------------------------------------
    localparam logic [1:0] PT_NONE = 2'h0;
    localparam logic [1:0] PT_RAMP = 2'h1;
    localparam logic [1:0] PT_PROFILE = 2'h2;
    localparam logic [1:0] EV_ALARM1 = 2'h1;
    localparam logic [1:0] EV_ALARM2 = 2'h2;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam int IRQ_W = 3;
    localparam int IRQ_SEG = 0;
    localparam int IRQ_DONE = 1;
    localparam int IRQ_HOLD = 2;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {SEQ_IDLE, SEQ_RUN, SEQ_DONE} sps_seq_t;

    typedef struct packed {
        logic awvalid;
        logic [31:0] awaddr;
        logic wvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bready;
        logic arvalid;
        logic [31:0] araddr;
        logic rready;
    } sps_axi_m2s_t;

    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } sps_axi_s2m_t;

    typedef struct packed {
        logic alarm1;
        logic alarm2;
    } sps_evt_t;

endpackage

// File: sps_div.sv
`timescale 1ns/1ps
module sps_div #(
    parameter int unsigned DIV = 60
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // enable in, one-cycle tick out
    input wire logic en,
    output logic tick
);
    typedef struct packed {
        logic [31:0] cnt;
        logic tick;
    } sps_div_st_t;

    sps_div_st_t s;
    sps_div_st_t next_s;

    always_comb begin
        next_s = s;
        next_s.tick = 1'b0;
        if (en) begin
            if (s.cnt == 32'(DIV - 1)) begin
                next_s.cnt = '0;
                next_s.tick = 1'b1;
            end else begin
                next_s.cnt = s.cnt + 32'h1;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign tick = s.tick;
endmodule // sps_div

// File: sps_sequencer.sv
`timescale 1ns/1ps
module sps_sequencer #(
    parameter int unsigned CYCLES_PER_SEC = sps_pkg::CYCLES_PER_SEC
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // register bus
    input wire sps_pkg::sps_axi_m2s_t axiIn,
    output sps_pkg::sps_axi_s2m_t axiOut,
    // control loop side
    input wire logic [15:0] measuredValue,
    output logic [15:0] workingSetpoint,
    // alarm logic side
    output sps_pkg::sps_evt_t eventReq,
    // interrupt
    output logic irq
);
    typedef struct packed {
        logic awHave;
        logic [11:0] awAddr;
        logic wHave;
        logic [31:0] wData;
        logic [3:0] wStrb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic [1:0] progType;
        logic timeSec;
        logic run;
        logic [2:0] profSel;
        logic [15:0] rate;
        logic [15:0] tol;
        logic [15:0] target;
        logic [sps_pkg::IRQ_W-1:0] irqStat;
        logic [sps_pkg::IRQ_W-1:0] irqMask;
        logic [sps_pkg::NUM_PROFILES-1:0][sps_pkg::MEM_WORDS-1:0][15:0] mem;
        sps_pkg::sps_seq_t state;
        logic [2:0] prof;
        logic [2:0] seg;
        logic [15:0] elapsed;
        logic [15:0] wsp;
        logic hold;
        logic runPrev;
        sps_pkg::sps_evt_t ev;
    } sps_st_t;

    sps_st_t s;
    sps_st_t next_s;
    logic secTick;
    logic minTick;

    // ------------------------------------------------------------
    // time base dividers
    // ------------------------------------------------------------
    sps_div #(.DIV(CYCLES_PER_SEC)) secDiv (
        .clk(clk),
        .rst_b(rst_b),
        .en(1'b1),
        .tick(secTick)
    );

    sps_div #(.DIV(sps_pkg::SEC_PER_MIN)) minDiv (
        .clk(clk),
        .rst_b(rst_b),
        .en(secTick),
        .tick(minTick)
    );

    function automatic logic memHit(input logic [11:0] a);
        logic [11:0] off;
        off = a - sps_pkg::MEM_BASE;
        memHit = (a >= sps_pkg::MEM_BASE) && (a < sps_pkg::MEM_END)
            && (off[5:2] < 4'(sps_pkg::MEM_WORDS));
    endfunction

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    localparam int IRQ_WIDTH = sps_pkg::IRQ_W;
    logic tick;
    logic runRise;
    logic [11:0] rAddr;
    logic [11:0] memOff;
    logic [31:0] rdVal;
    logic rdErr;
    logic wrErr;
    logic [IRQ_WIDTH-1:0] irqSet;
    logic [IRQ_WIDTH-1:0] irqClr;
    logic [3:0] segIdx;
    logic [15:0] curDur;
    logic [15:0] startSp;
    logic [15:0] endSp;
    logic signed [16:0] delta;
    logic signed [33:0] prod;
    logic signed [33:0] quo;
    logic [15:0] interp;
    logic signed [16:0] dev;
    logic [16:0] absDev;
    logic outside;
    logic signed [16:0] rampDiff;
    logic signed [16:0] rateS;
    logic enter;
    logic [2:0] linkTo;
    logic [1:0] evCode;

    always_comb begin
        next_s = s;
        next_s.ev = '0;
        irqSet = '0;
        irqClr = '0;
        wrErr = 1'b0;
        enter = 1'b0;
        linkTo = '0;
        evCode = '0;
        memOff = '0;
        rampDiff = '0;
        rateS = '0;

        // ---- write channel: address and data taken in either order
        if (!s.awHave && axiIn.awvalid) begin
            next_s.awHave = 1'b1;
            next_s.awAddr = axiIn.awaddr[11:0];
        end
        if (!s.wHave && axiIn.wvalid) begin
            next_s.wHave = 1'b1;
            next_s.wData = axiIn.wdata;
            next_s.wStrb = axiIn.wstrb;
        end
        if (s.awHave && s.wHave && !s.bvalid) begin
            next_s.awHave = 1'b0;
            next_s.wHave = 1'b0;
            next_s.bvalid = 1'b1;
            unique case (s.awAddr)
                sps_pkg::OFF_CTRL: begin
                    if (s.wStrb[0]) begin
                        next_s.progType = s.wData[1:0];
                        next_s.timeSec = s.wData[2];
                        next_s.run = s.wData[3];
                        next_s.profSel = s.wData[6:4];
                    end
                end
                sps_pkg::OFF_RATE: begin
                    if (s.wStrb[0]) next_s.rate[7:0] = s.wData[7:0];
                    if (s.wStrb[1]) next_s.rate[15:8] = s.wData[15:8];
                end
                sps_pkg::OFF_TOL: begin
                    if (s.wStrb[0]) next_s.tol[7:0] = s.wData[7:0];
                    if (s.wStrb[1]) next_s.tol[15:8] = s.wData[15:8];
                end
                sps_pkg::OFF_TARGET: begin
                    if (s.wStrb[0]) next_s.target[7:0] = s.wData[7:0];
                    if (s.wStrb[1]) next_s.target[15:8] = s.wData[15:8];
                end
                sps_pkg::OFF_IRQ_MASK: begin
                    if (s.wStrb[0]) next_s.irqMask = s.wData[IRQ_WIDTH-1:0];
                end
                sps_pkg::OFF_STATUS, sps_pkg::OFF_IRQ_STAT: begin
                end
                default: begin
                    if (memHit(s.awAddr)) begin
                        memOff = s.awAddr - sps_pkg::MEM_BASE;
                        if (s.wStrb[0]) begin
                            next_s.mem[memOff[8:6]][memOff[5:2]][7:0] = s.wData[7:0];
                        end
                        if (s.wStrb[1]) begin
                            next_s.mem[memOff[8:6]][memOff[5:2]][15:8] = s.wData[15:8];
                        end
                    end else begin
                        wrErr = 1'b1;
                    end
                end
            endcase
            next_s.bresp = wrErr ? sps_pkg::RESP_SLVERR : sps_pkg::RESP_OKAY;
        end
        if (s.bvalid && axiIn.bready) begin
            next_s.bvalid = 1'b0;
        end

        // ---- read channel
        rAddr = axiIn.araddr[11:0];
        rdVal = '0;
        rdErr = 1'b0;
        memOff = rAddr - sps_pkg::MEM_BASE;
        unique case (rAddr)
            sps_pkg::OFF_CTRL: rdVal = {25'h0, s.profSel, s.run, s.timeSec, s.progType};
            sps_pkg::OFF_RATE: rdVal = {16'h0, s.rate};
            sps_pkg::OFF_TOL: rdVal = {16'h0, s.tol};
            sps_pkg::OFF_TARGET: rdVal = {16'h0, s.target};
            sps_pkg::OFF_STATUS: rdVal = {s.wsp, 7'h0, s.hold, s.seg, s.prof, s.state};
            sps_pkg::OFF_IRQ_STAT: rdVal = {29'h0, s.irqStat};
            sps_pkg::OFF_IRQ_MASK: rdVal = {29'h0, s.irqMask};
            default: begin
                if (memHit(rAddr)) begin
                    rdVal = {16'h0, s.mem[memOff[8:6]][memOff[5:2]]};
                end else begin
                    rdErr = 1'b1;
                end
            end
        endcase
        if (axiIn.arvalid && !s.rvalid) begin
            next_s.rvalid = 1'b1;
            next_s.rdata = rdVal;
            next_s.rresp = rdErr ? sps_pkg::RESP_SLVERR : sps_pkg::RESP_OKAY;
            if (rAddr == sps_pkg::OFF_IRQ_STAT) begin
                irqClr = '1;
            end
        end
        if (s.rvalid && axiIn.rready) begin
            next_s.rvalid = 1'b0;
        end

        // ---- sequencer
        // one time unit drives durations and rate alike
        tick = s.timeSec ? secTick : minTick;
        runRise = s.run && !s.runPrev;
        next_s.runPrev = s.run;
        segIdx = 4'(s.seg) - 4'h1;
        curDur = s.mem[s.prof][sps_pkg::DUR_IDX0 + segIdx];
        startSp = s.mem[s.prof][segIdx];
        endSp = s.mem[s.prof][segIdx + 4'h1];
        delta = $signed({endSp[15], endSp}) - $signed({startSp[15], startSp});
        prod = 34'(delta * $signed({1'b0, s.elapsed}));
        quo = (curDur == '0) ? '0 : prod / $signed({18'h0, curDur});
        interp = startSp + quo[15:0];
        dev = $signed({measuredValue[15], measuredValue}) - $signed({s.wsp[15], s.wsp});
        absDev = dev[16] ? 17'(-dev) : 17'(dev);
        outside = (s.tol != '0) && (absDev > {1'b0, s.tol});

        unique case (s.state)
            sps_pkg::SEQ_IDLE: begin
                if (s.progType == sps_pkg::PT_PROFILE && runRise
                    && s.profSel >= sps_pkg::PROF_FIRST && s.profSel <= sps_pkg::PROF_LAST) begin
                    next_s.state = sps_pkg::SEQ_RUN;
                    next_s.prof = s.profSel - 3'h1;
                    next_s.seg = 3'h1;
                    enter = 1'b1;
                end
            end
            sps_pkg::SEQ_RUN: begin
                if (!s.run || s.progType != sps_pkg::PT_PROFILE) begin
                    next_s.state = sps_pkg::SEQ_IDLE;
                    next_s.hold = 1'b0;
                end else if (s.elapsed >= curDur) begin
                    next_s.wsp = endSp;
                    // profile ends after the fourth segment
                    if (s.seg == sps_pkg::NUM_SEG) begin
                        irqSet[sps_pkg::IRQ_DONE] = 1'b1;
                        linkTo = s.mem[s.prof][sps_pkg::LINK_IDX][2:0];
                        if (linkTo >= sps_pkg::PROF_FIRST && linkTo <= sps_pkg::PROF_LAST) begin
                            next_s.prof = linkTo - 3'h1;
                            next_s.seg = 3'h1;
                            enter = 1'b1;
                        end else begin
                            next_s.state = sps_pkg::SEQ_DONE;
                        end
                    end else begin
                        next_s.seg = s.seg + 3'h1;
                        enter = 1'b1;
                    end
                end else begin
                    next_s.wsp = interp;
                    // freeze time while out of band
                    next_s.hold = outside;
                    if (outside && !s.hold) begin
                        irqSet[sps_pkg::IRQ_HOLD] = 1'b1;
                    end
                    if (tick && !outside) begin
                        next_s.elapsed = s.elapsed + 16'h1;
                    end
                end
            end
            sps_pkg::SEQ_DONE: begin
                if (!s.run || s.progType != sps_pkg::PT_PROFILE) begin
                    next_s.state = sps_pkg::SEQ_IDLE;
                end
            end
            default: begin
                next_s.state = sps_pkg::SEQ_IDLE;
            end
        endcase

        if (enter) begin
            next_s.elapsed = '0;
            next_s.hold = 1'b0;
            irqSet[sps_pkg::IRQ_SEG] = 1'b1;
            evCode = s.mem[next_s.prof][sps_pkg::EVT_IDX][{next_s.seg - 3'h1, 1'b0} +: 2];
            next_s.ev.alarm1 = (evCode == sps_pkg::EV_ALARM1);
            next_s.ev.alarm2 = (evCode == sps_pkg::EV_ALARM2);
        end

        // no program follows target, ramp is rate limited
        if (s.progType == sps_pkg::PT_NONE) begin
            next_s.wsp = s.target;
        end else if (s.progType == sps_pkg::PT_RAMP) begin
            rampDiff = $signed({s.target[15], s.target}) - $signed({s.wsp[15], s.wsp});
            rateS = $signed({1'b0, s.rate});
            // step by rate per time unit
            if (tick) begin
                if (rampDiff > rateS) begin
                    next_s.wsp = s.wsp + s.rate;
                end else if (rampDiff < -rateS) begin
                    next_s.wsp = s.wsp - s.rate;
                end else begin
                    next_s.wsp = s.target;
                end
            end
        end

        // set wins over the read clear
        next_s.irqStat = (s.irqStat & ~irqClr) | irqSet;
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    // no new write is taken until the pending response is accepted
    assign axiOut.awready = !s.awHave && !s.bvalid;
    assign axiOut.wready = !s.wHave && !s.bvalid;
    assign axiOut.bvalid = s.bvalid;
    assign axiOut.bresp = s.bresp;
    assign axiOut.arready = !s.rvalid;
    assign axiOut.rvalid = s.rvalid;
    assign axiOut.rdata = s.rdata;
    assign axiOut.rresp = s.rresp;
    assign workingSetpoint = s.wsp;
    // alarm side filters by its own function setting
    assign eventReq = s.ev;
    assign irq = |(s.irqStat & s.irqMask);
endmodule // sps_sequencer

// File: sps_sequencer_sva.sv
`timescale 1ns/1ps
module sps_sequencer_sva #(
    parameter int unsigned CYCLES_PER_SEC = sps_pkg::CYCLES_PER_SEC
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // watched ports
    input wire sps_pkg::sps_axi_m2s_t axiIn,
    input wire sps_pkg::sps_axi_s2m_t axiOut,
    input wire logic [15:0] measuredValue,
    input wire logic [15:0] workingSetpoint,
    input wire sps_pkg::sps_evt_t eventReq,
    input wire logic irq
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    // ------------------------------------------------------------
    // bus handshake
    // ------------------------------------------------------------
    property p_b_stands;
        axiOut.bvalid && !axiIn.bready |=> axiOut.bvalid && $stable(axiOut.bresp);
    endproperty
    a_b_stands: assert property (p_b_stands) else $error("bvalid dropped early");
    property p_r_stands;
        axiOut.rvalid && !axiIn.rready |=> axiOut.rvalid && $stable(axiOut.rdata);
    endproperty
    a_r_stands: assert property (p_r_stands) else $error("rvalid dropped early");
    property p_r_answer;
        axiIn.arvalid && axiOut.arready |=> axiOut.rvalid;
    endproperty
    a_r_answer: assert property (p_r_answer) else $error("read answer late");
    property p_aw_refused;
        axiOut.bvalid |-> !axiOut.awready && !axiOut.wready;
    endproperty
    a_aw_refused: assert property (p_aw_refused) else $error("write taken during response");
    property p_ar_refused;
        axiOut.rvalid |-> !axiOut.arready;
    endproperty
    a_ar_refused: assert property (p_ar_refused) else $error("read taken during response");
    property p_r_done;
        axiOut.rvalid && axiIn.rready |=> !axiOut.rvalid;
    endproperty
    a_r_done: assert property (p_r_done) else $error("rvalid held after accept");
    property p_b_done;
        axiOut.bvalid && axiIn.bready |=> !axiOut.bvalid ##1 axiOut.awready;
    endproperty
    a_b_done: assert property (p_b_done) else $error("bvalid held after accept");
    property p_unmapped;
        axiIn.arvalid && axiOut.arready && axiIn.araddr[11:0] == 12'h020
            |=> axiOut.rresp == sps_pkg::RESP_SLVERR && axiOut.rdata == 32'h0;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not refused");

    // ------------------------------------------------------------
    // segment events
    // ------------------------------------------------------------
    property p_one_event;
        !(eventReq.alarm1 && eventReq.alarm2);
    endproperty
    a_one_event: assert property (p_one_event) else $error("two events at once");
endmodule // sps_sequencer_sva

// File: sps_loop_model.sv
`timescale 1ns/1ps
module sps_loop_model (
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // sequencer side
    input wire logic [15:0] workingSetpoint,
    input wire sps_pkg::sps_evt_t eventReq,
    output logic [15:0] measuredValue,
    // bench control
    input wire logic [15:0] offset,
    input wire logic [1:0] eventCfg,
    output logic [7:0] cnt1,
    output logic [7:0] cnt2
);
    // plant lags the setpoint by one cycle, offset models a disturbance
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            measuredValue <= 16'h0;
            cnt1 <= 8'h0;
            cnt2 <= 8'h0;
        end else begin
            measuredValue <= workingSetpoint + offset;
            if (eventReq.alarm1 && eventCfg[0]) cnt1 <= cnt1 + 8'h1;
            if (eventReq.alarm2 && eventCfg[1]) cnt2 <= cnt2 + 8'h1;
        end
    end
endmodule // sps_loop_model

// File: setpoint_profile_sequencer_tb.sv
`timescale 1ns/1ps
module setpoint_profile_sequencer_tb;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    sps_pkg::sps_axi_m2s_t m2s = '0;
    sps_pkg::sps_axi_s2m_t s2m;
    logic [15:0] pv, sp, offset = 16'h0;
    logic [1:0] eventCfg = 2'h3;
    logic [7:0] cnt1, cnt2;
    sps_pkg::sps_evt_t evt;
    logic irq;
    logic [31:0] rd;
    logic [1:0] rsp;
    logic [1:0] brsp;
    int errors = 0;
    int n_checks = 0;

    sps_sequencer #(.CYCLES_PER_SEC(10)) i_dut (.clk(clk), .rst_b(rst_b), .axiIn(m2s),
        .axiOut(s2m), .measuredValue(pv), .workingSetpoint(sp), .eventReq(evt), .irq(irq));
    sps_loop_model i_loop (.clk(clk), .rst_b(rst_b), .workingSetpoint(sp), .eventReq(evt),
        .measuredValue(pv), .offset(offset), .eventCfg(eventCfg), .cnt1(cnt1), .cnt2(cnt2));

    initial begin
        forever #2.5 clk = ~clk;
    end

    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic results();
        if (errors == 0 && n_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask

    // handshakes are judged at the negedge: the value the next rising edge samples
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic awT, wT, bT;
        int n;
        n = 0;
        @(posedge clk);
        m2s.awvalid <= 1'b1;
        m2s.awaddr <= a;
        m2s.wvalid <= 1'b1;
        m2s.wdata <= d;
        m2s.wstrb <= 4'hf;
        m2s.bready <= 1'b1;
        do begin
            @(negedge clk);
            awT = m2s.awvalid && s2m.awready;
            wT = m2s.wvalid && s2m.wready;
            bT = s2m.bvalid;
            brsp = s2m.bresp;
            @(posedge clk);
            if (awT) m2s.awvalid <= 1'b0;
            if (wT) m2s.wvalid <= 1'b0;
            if (bT) m2s.bready <= 1'b0;
            n++;
        end while (!bT && n < 100);
        if (!bT) errors++;
    endtask

    task automatic rdr(input logic [31:0] a);
        logic arT, rT;
        int n;
        n = 0;
        @(posedge clk);
        m2s.arvalid <= 1'b1;
        m2s.araddr <= a;
        m2s.rready <= 1'b1;
        do begin
            @(negedge clk);
            arT = m2s.arvalid && s2m.arready;
            rT = s2m.rvalid;
            rd = s2m.rdata;
            rsp = s2m.rresp;
            @(posedge clk);
            if (arT) m2s.arvalid <= 1'b0;
            if (rT) m2s.rready <= 1'b0;
            n++;
        end while (!rT && n < 100);
        if (!rT) errors++;
    endtask

    task automatic rdchk(input logic [31:0] a, input logic [31:0] m, input logic [31:0] e);
        rdr(a);
        chk(rd & m, e);
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        // look at outputs only once they have settled
        @(negedge clk);
    endtask

    task automatic start(input logic [31:0] c);
        wr(sps_pkg::OFF_CTRL, c);
        wr(sps_pkg::OFF_CTRL, c | 32'h8);
    endtask

    task automatic load(input int p, input int s0, input int ds, input int ev, input int lk);
        for (int f = 0; f < 11; f++)
            wr(32'h100 + p * 32'h40 + f * 4, f < 5 ? s0 + ds * f : f < 9 ? 1 : f == 9 ? ev : lk);
    endtask

    initial begin
        #100us;
        errors++;
        results();
    end

    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial begin
        repeat (20) @(posedge clk);
        rst_b <= 1'b1;
        chk({s2m.awready, s2m.arready, irq}, 32'h6);
        chk(sp, 32'h0);
        wr(sps_pkg::OFF_TARGET, 32'h0123);
        chk(brsp, 32'h0);
        cyc(3);
        chk(sp, 32'h0123);
        rdr(32'h020);
        chk(rsp, 32'h2);
        chk(rd, 32'h0);
        wr(32'h020, 32'h1);
        chk(brsp, 32'h2);
        wr(sps_pkg::OFF_TARGET, 32'h0);
        wr(sps_pkg::OFF_RATE, 32'h5);
        wr(sps_pkg::OFF_CTRL, 32'h5);
        wr(sps_pkg::OFF_TARGET, 32'h14);
        cyc(20);
        chk(sp == 16'h14, 32'h0);
        cyc(60);
        chk(sp, 32'h14);
        // profile 2 with a disturbance but check off
        load(1, 0, 10, 9, 0);
        wr(sps_pkg::OFF_TOL, 32'h0);
        offset <= 16'h64;
        wr(sps_pkg::OFF_IRQ_MASK, 32'h2);
        rdr(sps_pkg::OFF_IRQ_STAT);
        start(32'h26);
        cyc(25);
        chk(sp >= 16'ha && sp <= 16'h1e, 32'h1);
        cyc(40);
        rdchk(sps_pkg::OFF_STATUS, 32'h3, 32'h2);
        chk(sp, 32'h28);
        chk({cnt1, cnt2}, 32'h0101);
        chk(irq, 32'h1);
        rdchk(sps_pkg::OFF_IRQ_STAT, 32'h3, 32'h3);
        chk(irq, 32'h0);
        // hold while out of band
        wr(sps_pkg::OFF_IRQ_MASK, 32'h0);
        wr(sps_pkg::OFF_TOL, 32'h3);
        eventCfg <= 2'h1;
        start(32'h26);
        cyc(80);
        rdchk(sps_pkg::OFF_STATUS, 32'h103, 32'h101);
        offset <= 16'h0;
        cyc(80);
        rdchk(sps_pkg::OFF_STATUS, 32'h3, 32'h2);
        chk(irq, 32'h0);
        rdchk(sps_pkg::OFF_IRQ_STAT, 32'h7, 32'h7);
        chk({cnt1, cnt2}, 32'h0201);
        // chained profile
        wr(sps_pkg::OFF_TOL, 32'h0);
        load(2, 50, 0, 0, 0);
        wr(32'h168, 32'h3);
        start(32'h26);
        cyc(120);
        chk(sp, 32'h32);
        rdchk(sps_pkg::OFF_STATUS, 32'h1f, 32'ha);
        // minutes time base, 60 s per unit
        start(32'h32);
        cyc(100);
        rdchk(sps_pkg::OFF_STATUS, 32'h3, 32'h1);
        cyc(2500);
        rdchk(sps_pkg::OFF_STATUS, 32'h3, 32'h2);
        results();
    end
endmodule // setpoint_profile_sequencer_tb

bind sps_sequencer sps_sequencer_sva #(.CYCLES_PER_SEC(CYCLES_PER_SEC)) i_sva (.clk(clk),
    .rst_b(rst_b), .axiIn(axiIn), .axiOut(axiOut), .measuredValue(measuredValue),
    .workingSetpoint(workingSetpoint), .eventReq(eventReq), .irq(irq));
